// >>> rtl/touch_threshold_consts.vh
// Constants for the touch threshold register bank and its serial port.
// Assumes it is included by bare name from the rtl/ design files.
`ifndef TOUCH_THRESHOLD_CONSTS_VH
`define TOUCH_THRESHOLD_CONSTS_VH

// Register offsets
`define THR_REG_CH1_CH2    8'h02
`define THR_REG_CH3_CH4    8'h03
`define THR_REG_CH5_CH6    8'h04
`define THR_REG_CH7_CH8    8'h05
`define THR_REG_CH9_CH10   8'h06
`define THR_REG_CH11_CH12  8'h07
`define THR_NUM_REGS       6

// Field layout inside one register
`define THR_ODD_NIB_LSB    0
`define THR_EVEN_NIB_LSB   4
`define THR_CODE_LSB       0
`define THR_MARGIN_BIT     3

// Reset values
`define THR_CODE_RESET     3'h3
`define THR_MARGIN_RESET   1'h1
`define THR_REG_RESET      8'hBB

// Spread in tenths of the middle value
`define THR_SPREAD_NARROW  10'h002
`define THR_SPREAD_WIDE    10'h003
`define THR_SPREAD_DIV     10'h00A

// Middle threshold per code, scaled to cover thickness
`define THR_MID_C0         8'hF0
`define THR_MID_C1         8'hD0
`define THR_MID_C2         8'hB0
`define THR_MID_C3         8'h90
`define THR_MID_C4         8'h80
`define THR_MID_C5         8'h70
`define THR_MID_C6         8'h60
`define THR_MID_C7         8'h40

// Threshold values that follow from the reset setting
`define THR_MID_RESET      9'h090
`define THR_HIGH_RESET     9'h065
`define THR_LOW_RESET      9'h0BB

// Serial port
`define I2C_DEV_ADDR       7'h78
`define I2C_BITS_PER_BYTE  4'h8

`endif

// >>> rtl/pin_sync.v
// Three-stage synchroniser with agreement filter for slow pins.
// Assumes the pins are asynchronous to sys_clk and idle at RESET_VAL.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W         = 1,
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // Raw pins and filtered levels
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] pinOut
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : gSync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      // First stage feeds only the second; change counts when 2 and 3 agree
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          s1_q      <= RESET_VAL;
          s2_q      <= RESET_VAL;
          s3_q      <= RESET_VAL;
          pinOut[g] <= RESET_VAL;
        end else begin
          s1_q <= pinIn[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            pinOut[g] <= s3_q;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/threshold_calc.v
// One channel's high, middle and low touch thresholds.
// Assumes evalStrobe is a one-cycle pulse at the start of a sensing evaluation.
`timescale 1ns/1ps
`default_nettype none
`include "touch_threshold_consts.vh"
module threshold_calc (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Channel setting
  input  wire       evalStrobe,
  input  wire [2:0] middleThresholdCode,
  input  wire       marginSelect,
  // Thresholds in force
  output reg  [8:0] middleThreshold,
  output reg  [8:0] highThreshold,
  output reg  [8:0] lowThreshold
);
  reg  [7:0] midVal;
  wire [9:0] mid10;
  wire [9:0] prod;
  wire [9:0] spread;

  // Code to middle value; code 0 is the most sensitive step (see R3)
  always @* begin
    case (middleThresholdCode)
      3'h0:    midVal = `THR_MID_C0;
      3'h1:    midVal = `THR_MID_C1;
      3'h2:    midVal = `THR_MID_C2;
      3'h3:    midVal = `THR_MID_C3;
      3'h4:    midVal = `THR_MID_C4;
      3'h5:    midVal = `THR_MID_C5;
      3'h6:    midVal = `THR_MID_C6;
      default: midVal = `THR_MID_C7;
    endcase
  end

  // Only code and margin enter the spread (see R8)
  assign mid10  = {2'h0, midVal};
  assign prod   = mid10 * (marginSelect ? `THR_SPREAD_WIDE : `THR_SPREAD_NARROW); // see R5, see R6
  assign spread = prod / `THR_SPREAD_DIV;

  // Latched per evaluation so a mid-evaluation write cannot tear it
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      middleThreshold <= `THR_MID_RESET;
      highThreshold   <= `THR_HIGH_RESET;
      lowThreshold    <= `THR_LOW_RESET;
    end else if (evalStrobe) begin // see R11
      middleThreshold <= mid10[8:0];
      highThreshold   <= mid10[8:0] - spread[8:0]; // see R5, see R6
      lowThreshold    <= mid10[8:0] + spread[8:0];
    end
  end
endmodule
`default_nettype wire

// >>> rtl/touch_threshold_registers.v
// Threshold register bank for twelve touch channels, with its serial slave port.
// Assumes the serial pins come from the host directly and evalStrobe from the sensing core.
//
// Overview of operation
// R1: Six threshold registers at offsets 02h-07h.
// R2: Odd channel low nibble; margin bit on top.
// R3: Code selects eight steps; 000 most sensitive.
// R4: Middle codes reset to 011.
// R5: Margin 0 gives plus/minus 20 percent.
// R6: Margin 1 gives plus/minus 30 percent.
// R7: Margin bits reset to 1.
// R8: Thresholds depend only on code and margin.
// R9: Writes auto-increment offset until stop.
// R10: Host writes reserved bits as zero.
// R11: New setting applies at next evaluation.
`timescale 1ns/1ps
`default_nettype none
`include "touch_threshold_consts.vh"
module touch_threshold_registers (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // Serial port pins
  input  wire         scl,
  input  wire         sdaIn,
  output reg          sdaOut,
  output reg          sdaOe_n,
  input  wire         i2cEn_n,
  // Sensing core
  input  wire [11:0]  evalStrobe,
  output wire [107:0] middleThreshold,
  output wire [107:0] highThreshold,
  output wire [107:0] lowThreshold
);
  // Serial engine states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_PTR   = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_RDATA = 3'h4;
  localparam [2:0] ST_ACK   = 3'h5;
  localparam [2:0] ST_MACK  = 3'h6;

  // Filtered pins and bus events
  wire [2:0]  pinsF;
  wire        sclF;
  wire        sdaF;
  wire        enF_n;
  reg         sclPrev_q;
  reg         sdaPrev_q;
  wire        sclRise;
  wire        sclFall;
  wire        startCond;
  wire        stopCond;

  // Serial engine
  reg  [2:0]  state_q;
  reg  [2:0]  afterAck_q;
  reg  [3:0]  bitCnt_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  ptr_q;
  wire        byteDone;

  // Register bank and its access decode
  reg  [47:0] thrBank_q;
  wire        wrStrobe;
  wire [3:0]  wrHit;
  wire [3:0]  rdHit;
  wire [5:0]  regWe;
  reg  [7:0]  rdByte;
  wire [7:0]  thrCh1Ch2;
  wire [7:0]  thrCh3Ch4;
  wire [7:0]  thrCh5Ch6;
  wire [7:0]  thrCh7Ch8;
  wire [7:0]  thrCh9Ch10;
  wire [7:0]  thrCh11Ch12;

  // Offset decode, shared by read and write: {hit, index}
  function [3:0] regIndex;
    input [7:0] off;
    begin
      case (off)
        `THR_REG_CH1_CH2:   regIndex = 4'h8; // see R1
        `THR_REG_CH3_CH4:   regIndex = 4'h9;
        `THR_REG_CH5_CH6:   regIndex = 4'hA;
        `THR_REG_CH7_CH8:   regIndex = 4'hB;
        `THR_REG_CH9_CH10:  regIndex = 4'hC;
        `THR_REG_CH11_CH12: regIndex = 4'hD;
        default:            regIndex = 4'h0;
      endcase
    end
  endfunction

  // Bit position of a channel's nibble; odd channels take the low half
  function integer nibLsb;
    input integer ch;
    begin
      if ((ch % 2) == 0) begin
        nibLsb = (ch / 2) * 8 + `THR_ODD_NIB_LSB;
      end else begin
        nibLsb = (ch / 2) * 8 + `THR_EVEN_NIB_LSB;
      end
    end
  endfunction

  // Pins are asynchronous; filtered before any edge logic looks at them
  pin_sync #(
    .W         (3),
    .RESET_VAL (1'b1)
  ) uPinSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   ({i2cEn_n, sdaIn, scl}),
    .pinOut  (pinsF)
  );
  // Filtered levels in pin order
  assign sclF  = pinsF[0];
  assign sdaF  = pinsF[1];
  assign enF_n = pinsF[2];

  // Previous filtered levels for edge and bus condition detection
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= sclF;
      sdaPrev_q <= sdaF;
    end
  end

  // Edges and bus conditions; start and stop need scl high on both samples
  assign sclRise   = sclF & ~sclPrev_q;
  assign sclFall   = ~sclF & sclPrev_q;
  assign startCond = sclF & sclPrev_q & sdaPrev_q & ~sdaF;
  assign stopCond  = sclF & sclPrev_q & ~sdaPrev_q & sdaF;
  assign byteDone  = sclFall & (bitCnt_q == `I2C_BITS_PER_BYTE);

  // Data byte lands at the pointer on its eighth falling clock edge
  assign wrStrobe = (state_q == ST_WDATA) & byteDone & ~enF_n & ~startCond & ~stopCond;
  assign wrHit    = regIndex(ptr_q);
  assign rdHit    = regIndex(ptr_q);

  // Named views of the six registers, in offset order
  assign thrCh1Ch2   = thrBank_q[7:0];
  assign thrCh3Ch4   = thrBank_q[15:8];
  assign thrCh5Ch6   = thrBank_q[23:16];
  assign thrCh7Ch8   = thrBank_q[31:24];
  assign thrCh9Ch10  = thrBank_q[39:32];
  assign thrCh11Ch12 = thrBank_q[47:40];

  // Read mux; offsets outside the bank read as zero
  always @* begin
    rdByte = 8'h00;
    if (rdHit[3]) begin
      case (rdHit[2:0])
        3'h0:    rdByte = thrCh1Ch2;
        3'h1:    rdByte = thrCh3Ch4;
        3'h2:    rdByte = thrCh5Ch6;
        3'h3:    rdByte = thrCh7Ch8;
        3'h4:    rdByte = thrCh9Ch10;
        3'h5:    rdByte = thrCh11Ch12;
        default: rdByte = 8'h00;
      endcase
    end
  end

  // Register storage; every bit is a field, so nothing is masked
  genvar r;
  generate
    for (r = 0; r < `THR_NUM_REGS; r = r + 1) begin : gReg
      // Write enable of this register, decoded from the pointer
      assign regWe[r] = wrStrobe & wrHit[3] & (wrHit[2:0] == r);
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          thrBank_q[8*r +: 8] <= `THR_REG_RESET; // see R4, see R7
        end else if (regWe[r]) begin
          thrBank_q[8*r +: 8] <= shift_q; // see R1
        end
      end
    end
  endgenerate

  // Serial slave engine; open drain, so sdaOut stays low and only the enable moves
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      afterAck_q <= ST_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      sdaOut     <= 1'b0;
      sdaOe_n    <= 1'b1;
    end else if (enF_n || stopCond) begin
      // Port disabled or stop: release the line, the pointer is kept
      state_q  <= ST_IDLE; // see R9
      sdaOe_n  <= 1'b1;
      bitCnt_q <= 4'h0;
    end else if (startCond) begin
      // Start or repeated start restarts address reception while the port is enabled
      state_q  <= ST_ADDR;
      sdaOe_n  <= 1'b1;
      bitCnt_q <= 4'h0;
    end else begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise) begin
            shift_q  <= {shift_q[6:0], sdaF};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteDone) begin
            bitCnt_q <= 4'h0;
            if (state_q == ST_ADDR) begin
              if (shift_q[7:1] == `I2C_DEV_ADDR) begin
                sdaOe_n    <= 1'b0;
                state_q    <= ST_ACK;
                afterAck_q <= shift_q[0] ? ST_RDATA : ST_PTR;
              end else begin
                state_q <= ST_IDLE; // not for us
              end
            end else if (state_q == ST_PTR) begin
              ptr_q      <= shift_q; // see R9
              sdaOe_n    <= 1'b0;
              state_q    <= ST_ACK;
              afterAck_q <= ST_WDATA;
            end else begin
              // Any offset is acknowledged; writes outside the bank drop
              ptr_q      <= ptr_q + 8'h01; // see R9
              sdaOe_n    <= 1'b0;
              state_q    <= ST_ACK;
              afterAck_q <= ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (afterAck_q == ST_RDATA) begin
              shift_q  <= rdByte;
              sdaOe_n  <= rdByte[7];
              ptr_q    <= ptr_q + 8'h01;
              bitCnt_q <= 4'h0;
              state_q  <= ST_RDATA;
            end else begin
              sdaOe_n <= 1'b1;
              state_q <= afterAck_q;
            end
          end
        end
        ST_RDATA: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (byteDone) begin
            sdaOe_n  <= 1'b1; // host drives its acknowledge
            bitCnt_q <= 4'h0;
            state_q  <= ST_MACK;
          end else if (sclFall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            sdaOe_n <= shift_q[6];
          end
        end
        ST_MACK: begin
          if (sclRise && sdaF) begin
            state_q <= ST_IDLE; // host ends the read
          end else if (sclFall) begin
            shift_q <= rdByte;
            sdaOe_n <= rdByte[7];
            ptr_q   <= ptr_q + 8'h01;
            state_q <= ST_RDATA;
          end
        end
        ST_IDLE: begin
          // Not addressed: the bus is ignored until the next start
          sdaOe_n <= 1'b1;
        end
        default: begin
          sdaOe_n <= 1'b1;
        end
      endcase
    end
  end

  // One threshold unit per channel; odd channel in the low nibble
  genvar c;
  generate
    for (c = 0; c < 12; c = c + 1) begin : gCh
      localparam NIB = nibLsb(c); // see R2
      wire [2:0] chCode;
      wire       chMargin;
      // This channel's two fields, picked out of its register
      assign chCode   = thrBank_q[NIB + `THR_CODE_LSB +: 3];
      assign chMargin = thrBank_q[NIB + `THR_MARGIN_BIT];
      threshold_calc uCalc (
        .sys_clk             (sys_clk),
        .rst                 (rst),
        .evalStrobe          (evalStrobe[c]),
        .middleThresholdCode (chCode),
        .marginSelect        (chMargin),
        .middleThreshold     (middleThreshold[9*c +: 9]),
        .highThreshold       (highThreshold[9*c +: 9]),
        .lowThreshold        (lowThreshold[9*c +: 9])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// >>> verification/touch_threshold_registers_props.sv
// Port assertions for the threshold bank.
// Assumes a bind to touch_threshold_registers.
`timescale 1ns/1ps
`default_nettype none
`include "touch_threshold_consts.vh"
module touch_threshold_registers_props (
  // Clock, reset and serial pins
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire logic         scl,
  input wire logic         sdaOut,
  input wire logic         sdaOe_n,
  // Sensing side
  input wire logic [11:0]  evalStrobe,
  input wire logic [107:0] middleThreshold,
  input wire logic [107:0] highThreshold,
  input wire logic [107:0] lowThreshold
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Writes alone must never move what sensing uses
  a_mid_hold: assert property (!evalStrobe |=> $stable(middleThreshold))
    else $error("middle moved without strobe");
  a_edge_hold: assert property ((evalStrobe == 12'h000) [*2] |-> $stable({highThreshold, lowThreshold}))
    else $error("edge level moved without strobe");
  // First cycle out of reset shows the default setting
  a_reset_out: assert property ($past(rst) |-> middleThreshold == {12{`THR_MID_RESET}} &&
    highThreshold == {12{`THR_HIGH_RESET}} && lowThreshold == {12{`THR_LOW_RESET}})
    else $error("wrong level after reset");
  // Device only pulls the line, takes it only while the clock is low and holds it steady while high
  a_drive_low: assert property ($fell(sdaOe_n) |-> !scl && !sdaOut)
    else $error("line taken with clock high");
  a_sda_steady: assert property (scl [*6] |-> $stable(sdaOe_n))
    else $error("line moved while clock high");
  // Per-channel shape; 12 bits so the 3x product cannot wrap
  for (genvar c = 0; c < 12; c++) begin : g_ch
    wire [11:0] m = {3'h0, middleThreshold[9*c +: 9]};
    wire [11:0] h = {3'h0, highThreshold[9*c +: 9]};
    wire [11:0] l = {3'h0, lowThreshold[9*c +: 9]};
    a_spread_even: assert property (l - m == m - h)
      else $error("uneven spread");
    a_spread_size: assert property ((m - h) * 12'h00A <= m * 12'h003 &&
      (m - h + 12'h001) * 12'h00A > m * 12'h002)
      else $error("spread out of range");
    a_mid_steps: assert property (m inside {`THR_MID_C0, `THR_MID_C1, `THR_MID_C2, `THR_MID_C3,
      `THR_MID_C4, `THR_MID_C5, `THR_MID_C6, `THR_MID_C7})
      else $error("middle not a step");
  end
endmodule
`default_nettype wire

// >>> verification/i2c_host_model.sv
// Behavioural host that masters the two-wire port.
// Assumes sda is an open-drain line with a pull-up in the bench.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Pacing clock
  input  wire logic sys_clk,
  // Bus lines
  input  wire logic sda,
  output var logic  scl,
  output var logic  sdaLow
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Ten clocks per step keeps each phase clear of the pin filter
  task automatic gap();
    repeat (10) @(negedge sys_clk);
  endtask
  // Also a repeated start; data moves a step after scl falls
  task automatic startBit();
    gap();
    sdaLow = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sdaLow = 1'b1;
    gap();
    scl = 1'b0;
  endtask
  // Stop ends the transfer
  task automatic stopBit();
    gap();
    sdaLow = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sdaLow = 1'b0;
    gap();
  endtask
  // Eight bits and the ack slot, sampled late in the high phase
  task automatic xfer(input logic [7:0] dOut, input logic ackOut, output logic [7:0] dIn, output logic ackIn);
    logic [8:0] sh;
    logic [8:0] rx;
    sh = {dOut, ackOut};
    for (int i = 8; i >= 0; i--) begin
      gap();
      sdaLow = !sh[i];
      gap();
      scl = 1'b1;
      gap();
      rx[i] = sda;
      scl = 1'b0;
    end
    {dIn, ackIn} = rx;
  endtask
endmodule
`default_nettype wire

// >>> verification/touch_threshold_registers_test.sv
// Self-checking bench for the threshold bank.
// Assumes the host model and the port checker beside it.
`timescale 1ns/1ps
`default_nettype none
`include "touch_threshold_consts.vh"
module touch_threshold_registers_test;
  logic           sys_clk = 1'b0;
  logic           rst;
  logic           i2cEn_n;
  logic [11:0]    evalStrobe;
  wire            scl;
  wire            hostLow;
  wire            sdaOut;
  wire            sdaOe_n;
  wire            sdaLine;
  wire  [107:0]   middleThreshold;
  wire  [107:0]   highThreshold;
  wire  [107:0]   lowThreshold;
  int             n_errors = 0;
  int             cmp_count = 0;
  // Open-drain wire with pull-up
  assign sdaLine = ~((~sdaOe_n & ~sdaOut) | hostLow);
  always #2.5 sys_clk = ~sys_clk;
  touch_threshold_registers u_dut (.sys_clk(sys_clk), .rst(rst), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .i2cEn_n(i2cEn_n), .evalStrobe(evalStrobe),
    .middleThreshold(middleThreshold), .highThreshold(highThreshold), .lowThreshold(lowThreshold));
  i2c_host_model u_host (.sys_clk(sys_clk), .sda(sdaLine), .scl(scl), .sdaLow(hostLow));
  task automatic results();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Channel index c gets code c mod 8 and margin c[1]
  function automatic logic [3:0] nib(input int c);
    nib = {c[1], c[2:0]};
  endfunction
  function automatic logic [47:0] pat();
    for (int k = 0; k < 6; k++) begin
      pat[47-8*k -: 8] = {nib(2*k+1), nib(2*k)};
    end
  endfunction
  // Expected middle, high and low of one nibble
  function automatic logic [26:0] thr(input logic [3:0] n);
    logic [7:0] mids [8];
    logic [11:0] m;
    logic [11:0] s;
    mids = '{`THR_MID_C0, `THR_MID_C1, `THR_MID_C2, `THR_MID_C3, `THR_MID_C4, `THR_MID_C5, `THR_MID_C6, `THR_MID_C7};
    m = {4'h0, mids[n[2:0]]};
    s = m * (n[3] ? 12'h003 : 12'h002) / 12'h00A;
    thr = {m[8:0], m[8:0] - s[8:0], m[8:0] + s[8:0]};
  endfunction
  task automatic chkOut(input logic [11:0] newMask);
    for (int c = 0; c < 12; c++) begin
      check({middleThreshold[9*c +: 9], highThreshold[9*c +: 9], lowThreshold[9*c +: 9]},
        newMask[c] ? thr(nib(c)) : thr(4'hB));
    end
  endtask
  task automatic strobe(input logic [11:0] m);
    @(negedge sys_clk) evalStrobe = m;
    @(negedge sys_clk) evalStrobe = 12'h000;
    @(negedge sys_clk);
  endtask
  task automatic putByte(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    u_host.xfer(d, 1'b1, q, a);
    check(a, 1'b0);
  endtask
  task automatic wrRegs(input logic [7:0] off, input logic [47:0] d, input int n);
    u_host.startBit();
    putByte({`I2C_DEV_ADDR, 1'b0});
    putByte(off);
    for (int i = 0; i < n; i++) begin
      putByte(d[47-8*i -: 8]);
    end
    u_host.stopBit();
  endtask
  task automatic rdRegs(input logic [7:0] off, input logic [47:0] d, input int n);
    logic [7:0] q;
    logic a;
    wrRegs(off, 48'h0, 0);
    u_host.startBit();
    putByte({`I2C_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hFF, i == n - 1, q, a);
      check(q, d[47-8*i -: 8]);
    end
    u_host.stopBit();
  endtask
  task automatic sReset();
    chkOut(12'h000);
    rdRegs(8'h02, {6{8'hBB}}, 6);
  endtask
  task automatic sWrite();
    wrRegs(8'h02, pat(), 6);
    chkOut(12'h000);
    rdRegs(8'h02, pat(), 6);
  endtask
  task automatic sEval();
    strobe(12'h555);
    chkOut(12'h555);
    strobe(12'hAAA);
    chkOut(12'hFFF);
  endtask
  // Run past the last register, then a foreign address
  task automatic sEdge();
    logic [7:0] q;
    logic a;
    wrRegs(8'h07, {8'h3C, 8'h5A, 32'h0}, 2);
    // Port disabled: address goes unanswered and the write must not land
    i2cEn_n = 1'b1;
    u_host.startBit();
    u_host.xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1, q, a);
    check(a, 1'b1);
    u_host.xfer(8'h07, 1'b1, q, a);
    u_host.xfer(8'h00, 1'b1, q, a);
    u_host.stopBit();
    i2cEn_n = 1'b0;
    rdRegs(8'h07, {8'h3C, 8'h00, 32'h0}, 2);
    u_host.startBit();
    u_host.xfer(8'hF2, 1'b1, q, a);
    check(a, 1'b1);
    u_host.stopBit();
  endtask
  // Watchdog against a stuck run
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    results();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    i2cEn_n = 1'b0;
    evalStrobe = 12'h000;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    sReset();
    sWrite();
    sEval();
    sEdge();
    results();
  end
endmodule
bind touch_threshold_registers touch_threshold_registers_props u_props (.sys_clk(sys_clk), .rst(rst),
  .scl(scl), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .evalStrobe(evalStrobe),
  .middleThreshold(middleThreshold), .highThreshold(highThreshold), .lowThreshold(lowThreshold));
`default_nettype wire
